// ===== hw/msr_pkg.sv
// constants, types and reset table for the mode decode and register map
// assumes a single clock domain and an 8-bit internal cpu register port
`default_nettype none

package msr_pkg;

    // operating modes
    typedef enum logic [2:0]
    {
        MSR_MODE_NONE = 3'b000,
        MSR_MODE_EXP1 = 3'b001,
        MSR_MODE_EXP2 = 3'b010,
        MSR_MODE_SINGLE = 3'b011,
        MSR_MODE_PROM = 3'b100
    } msr_mode_t;

    // access classes of the register area
    typedef enum logic [1:0]
    {
        MSR_ACC_RW = 2'b00,
        MSR_ACC_WO = 2'b01,
        MSR_ACC_RO = 2'b10,
        MSR_ACC_RSVD = 2'b11
    } msr_acc_t;

    // register offsets
    localparam logic [4:0] MSR_P2_DIR = 5'h01;
    localparam logic [4:0] MSR_P1_LATCH = 5'h02;
    localparam logic [4:0] MSR_P2_DATA = 5'h03;
    localparam logic [4:0] MSR_P3_DIR = 5'h04;
    localparam logic [4:0] MSR_P3_DATA = 5'h06;
    localparam logic [4:0] MSR_P4_LATCH = 5'h07;
    localparam logic [4:0] MSR_T1_CSR_A = 5'h08;
    localparam logic [4:0] MSR_FRC_HI = 5'h09;
    localparam logic [4:0] MSR_FRC_LO = 5'h0A;
    localparam logic [4:0] MSR_CMP1_HI = 5'h0B;
    localparam logic [4:0] MSR_CMP1_LO = 5'h0C;
    localparam logic [4:0] MSR_CAP_HI = 5'h0D;
    localparam logic [4:0] MSR_CAP_LO = 5'h0E;
    localparam logic [4:0] MSR_T1_CSR_B = 5'h0F;
    localparam logic [4:0] MSR_SER_RATE = 5'h10;
    localparam logic [4:0] MSR_SER_CTRL = 5'h11;
    localparam logic [4:0] MSR_SER_RXBUF = 5'h12;
    localparam logic [4:0] MSR_SER_TXBUF = 5'h13;
    localparam logic [4:0] MSR_RAM_P5_CTRL = 5'h14;
    localparam logic [4:0] MSR_P5_IN = 5'h15;
    localparam logic [4:0] MSR_P6_DIR = 5'h16;
    localparam logic [4:0] MSR_P6_DATA = 5'h17;
    localparam logic [4:0] MSR_P7_LATCH = 5'h18;
    localparam logic [4:0] MSR_CMP2_HI = 5'h19;
    localparam logic [4:0] MSR_CMP2_LO = 5'h1A;
    localparam logic [4:0] MSR_T_CSR_C = 5'h1B;
    localparam logic [4:0] MSR_T2_RELOAD = 5'h1C;
    localparam logic [4:0] MSR_T2_COUNT = 5'h1D;

    // reset values
    localparam logic [7:0] MSR_RST_P2_DIR = 8'hFC;
    localparam logic [7:0] MSR_RST_P3_DIR = 8'hFE;
    localparam logic [7:0] MSR_RST_P6_DIR = 8'h00;
    localparam logic [7:0] MSR_RST_CMP = 8'hFF;
    localparam logic [7:0] MSR_RST_ZERO = 8'h00;
    localparam logic [7:0] MSR_RST_T1_CSR_B = 8'h10;
    localparam logic [7:0] MSR_RST_T_CSR_C = 8'h20;
    localparam logic [7:0] MSR_RST_T2_RELOAD = 8'hFF;
    localparam logic [7:0] MSR_RST_SER_CTRL = 8'h20;
    localparam logic [7:0] MSR_RST_RAM_CTRL_LOW = 8'h7C;
    localparam logic [7:0] MSR_RST_RAM_CTRL_HIGH = 8'hFC;
    // value returned by write-only and reserved locations
    localparam logic [7:0] MSR_UNDEF_READ = 8'hFF;

    // field positions
    localparam int unsigned MSR_INTERNAL_RAM_ENABLE_BIT = 6;

    // memory map
    localparam logic [15:0] MSR_REG_AREA_END = 16'h001F;
    localparam logic [15:0] MSR_RAM_BASE = 16'h0040;
    localparam logic [15:0] MSR_RAM_END = 16'h00FF;
    localparam logic [15:0] MSR_ROM_BASE = 16'hF000;

    function automatic logic [7:0] msr_reset_value(input logic [4:0] idx, input logic ram_hi);
        logic [7:0] v;
        v = MSR_RST_ZERO;
        unique case (idx)
            MSR_P2_DIR: v = MSR_RST_P2_DIR;
            MSR_P3_DIR: v = MSR_RST_P3_DIR;
            MSR_P6_DIR: v = MSR_RST_P6_DIR;
            MSR_CMP1_HI, MSR_CMP1_LO, MSR_CMP2_HI, MSR_CMP2_LO: v = MSR_RST_CMP;
            MSR_T1_CSR_B: v = MSR_RST_T1_CSR_B;
            MSR_T_CSR_C: v = MSR_RST_T_CSR_C;
            MSR_T2_RELOAD: v = MSR_RST_T2_RELOAD;
            MSR_SER_CTRL: v = MSR_RST_SER_CTRL;
            MSR_RAM_P5_CTRL: v = ram_hi ? MSR_RST_RAM_CTRL_HIGH : MSR_RST_RAM_CTRL_LOW;
            default: v = MSR_RST_ZERO;
        endcase
        return v;
    endfunction

    function automatic msr_acc_t msr_access(input logic [4:0] idx);
        msr_acc_t a;
        a = MSR_ACC_RSVD;
        unique case (idx)
            MSR_P2_DIR, MSR_P3_DIR, MSR_P6_DIR, MSR_SER_TXBUF, MSR_T2_RELOAD: a = MSR_ACC_WO;
            MSR_CAP_HI, MSR_CAP_LO, MSR_SER_RXBUF, MSR_P5_IN: a = MSR_ACC_RO;
            MSR_P1_LATCH, MSR_P2_DATA, MSR_P3_DATA, MSR_P4_LATCH, MSR_T1_CSR_A,
            MSR_FRC_HI, MSR_FRC_LO, MSR_CMP1_HI, MSR_CMP1_LO, MSR_T1_CSR_B,
            MSR_SER_RATE, MSR_SER_CTRL, MSR_RAM_P5_CTRL, MSR_P6_DATA, MSR_P7_LATCH,
            MSR_CMP2_HI, MSR_CMP2_LO, MSR_T_CSR_C, MSR_T2_COUNT: a = MSR_ACC_RW;
            default: a = MSR_ACC_RSVD;
        endcase
        return a;
    endfunction

endpackage

`default_nettype wire

// ===== hw/msr_regmap.sv
// operating mode decode and internal register area of the microcomputer
// assumes the cpu core presents one-cycle read and write strobes on clk
//
// Summary of operation
// - mode pins plus standby select the mode
// - mode 1: rom off, external vectors, 65k
// - mode 2: rom and vectors internal, 61k
// - mode 3: no external access, ports general
// - prom mode holds processor inactive
// - expanded modes: ports 3,1,4,7 form bus
// - rom-less variant supports only mode 1
// - addresses 0 to 31 are register area
// - direction registers write-only, reset fc/fe/00
// - both compare registers reset to ff
// - capture read-only; counter, csr a zero
// - timer csr b resets to 10
// - csr c 20, reload wo ff, count 00
// - serial ctrl 20; rx ro, tx wo, zero
// - ram/port5 ctrl 7c or fc; port5 read-only
// - ram enable bit 6 gates internal ram
`timescale 1ns/10ps
`default_nettype none

module msr_regmap
#(
    parameter bit HAS_ROM = 1'b1,
    parameter bit RAM_CTRL_RESET_HIGH = 1'b0
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_select_pin_a,
    input wire logic mode_select_pin_b,
    input wire logic standby_input,
    input wire logic [7:0] port5_pins,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [15:0] capture_value,
    input wire logic [7:0] rx_data,
    output logic [7:0] cpu_rdata_q,
    output logic cpu_rvalid_q,
    output logic reg_hit_q,
    output logic ext_access_q,
    output logic rom_access_q,
    output logic ram_access_q,
    output msr_pkg::msr_mode_t mode_q,
    output logic rom_enable_q,
    output logic ext_vectors_q,
    output logic ext_bus_enable_q,
    output logic cpu_hold_q,
    output logic internal_ram_enable_q,
    output logic [7:0] port2_dir_q,
    output logic [7:0] port3_dir_q,
    output logic [7:0] port6_dir_q
);

    // ********************************************
    // pin synchronisers
    // ********************************************
    logic [2:0] pins_meta_q;
    logic [2:0] pins_sync_q;
    logic [7:0] p5_meta_q;
    logic [7:0] p5_sync_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pins_meta_q <= 3'h7;
            pins_sync_q <= 3'h7;
            p5_meta_q <= 8'h00;
            p5_sync_q <= 8'h00;
        end
        else
        begin
            pins_meta_q <= {standby_input, mode_select_pin_b, mode_select_pin_a};
            pins_sync_q <= pins_meta_q;
            p5_meta_q <= port5_pins;
            p5_sync_q <= p5_meta_q;
        end
    end

    // ********************************************
    // mode decode
    // ********************************************
    msr_pkg::msr_mode_t mode_d;

    always_comb
    begin
        unique case (pins_sync_q[1:0])
            2'b01: mode_d = msr_pkg::MSR_MODE_EXP1;
            2'b10: mode_d = msr_pkg::MSR_MODE_EXP2;
            2'b11: mode_d = msr_pkg::MSR_MODE_SINGLE;
            default: mode_d = pins_sync_q[2] ? msr_pkg::MSR_MODE_NONE
                                             : msr_pkg::MSR_MODE_PROM;
        endcase
        if (!HAS_ROM)
        begin
            mode_d = msr_pkg::MSR_MODE_EXP1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= msr_pkg::MSR_MODE_NONE;
            rom_enable_q <= 1'b0;
            ext_vectors_q <= 1'b0;
            ext_bus_enable_q <= 1'b0;
            cpu_hold_q <= 1'b1;
        end
        else
        begin
            mode_q <= mode_d;
            // mode 1 fetches vectors outside, others inside
            rom_enable_q <= (mode_d == msr_pkg::MSR_MODE_EXP2)
                            || (mode_d == msr_pkg::MSR_MODE_SINGLE);
            ext_vectors_q <= (mode_d == msr_pkg::MSR_MODE_EXP1);
            // ports 3/1/4/7 carry data, address and strobes
            ext_bus_enable_q <= (mode_d == msr_pkg::MSR_MODE_EXP1)
                                || (mode_d == msr_pkg::MSR_MODE_EXP2);
            cpu_hold_q <= (mode_d == msr_pkg::MSR_MODE_PROM)
                          || (mode_d == msr_pkg::MSR_MODE_NONE);
        end
    end

    // ********************************************
    // address region decode
    // ********************************************
    logic in_regs;
    logic in_ram;
    logic in_rom;

    assign in_regs = (cpu_addr <= msr_pkg::MSR_REG_AREA_END);
    assign in_ram = (cpu_addr >= msr_pkg::MSR_RAM_BASE) && (cpu_addr <= msr_pkg::MSR_RAM_END);
    assign in_rom = (cpu_addr >= msr_pkg::MSR_ROM_BASE);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_hit_q <= 1'b0;
            ram_access_q <= 1'b0;
            rom_access_q <= 1'b0;
            ext_access_q <= 1'b0;
        end
        else if ((cpu_rd || cpu_wr) && !cpu_hold_q)
        begin
            reg_hit_q <= in_regs;
            // disabled ram is neither read nor written
            ram_access_q <= in_ram && internal_ram_enable_q;
            // rom window takes the top 4k only when enabled
            rom_access_q <= in_rom && rom_enable_q;
            ext_access_q <= ext_bus_enable_q && !in_regs
                            && !(in_ram && internal_ram_enable_q)
                            && !(in_rom && rom_enable_q);
        end
        else
        begin
            reg_hit_q <= 1'b0;
            ram_access_q <= 1'b0;
            rom_access_q <= 1'b0;
            ext_access_q <= 1'b0;
        end
    end

    // ********************************************
    // register storage
    // ********************************************
    logic [7:0] regs_q [32];
    logic reg_wr;
    logic reg_rd;
    logic [4:0] idx;

    assign idx = cpu_addr[4:0];
    assign reg_wr = cpu_wr && in_regs && !cpu_hold_q;
    assign reg_rd = cpu_rd && in_regs && !cpu_hold_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 32; i++)
            begin
                regs_q[i] <= msr_pkg::msr_reset_value(5'(i), RAM_CTRL_RESET_HIGH);
            end
        end
        else if (reg_wr)
        begin
            // read-only and reserved locations drop the write
            if ((msr_pkg::msr_access(idx) == msr_pkg::MSR_ACC_RW)
                || (msr_pkg::msr_access(idx) == msr_pkg::MSR_ACC_WO))
            begin
                regs_q[idx] <= cpu_wdata;
            end
        end
    end

    // ********************************************
    // read path
    // ********************************************
    logic [7:0] rd_d;

    always_comb
    begin
        unique case (msr_pkg::msr_access(idx))
            msr_pkg::MSR_ACC_RW: rd_d = regs_q[idx];
            msr_pkg::MSR_ACC_WO: rd_d = msr_pkg::MSR_UNDEF_READ;
            msr_pkg::MSR_ACC_RO:
            begin
                unique case (idx)
                    msr_pkg::MSR_CAP_HI: rd_d = capture_value[15:8];
                    msr_pkg::MSR_CAP_LO: rd_d = capture_value[7:0];
                    msr_pkg::MSR_SER_RXBUF: rd_d = rx_data;
                    default: rd_d = p5_sync_q;
                endcase
            end
            default: rd_d = msr_pkg::MSR_UNDEF_READ;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_rdata_q <= 8'h00;
            cpu_rvalid_q <= 1'b0;
        end
        else
        begin
            cpu_rvalid_q <= reg_rd;
            if (reg_rd)
            begin
                cpu_rdata_q <= rd_d;
            end
        end
    end

    // ********************************************
    // control outputs mirrored from the map
    // ********************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            internal_ram_enable_q <= 1'b1;
            port2_dir_q <= msr_pkg::MSR_RST_P2_DIR;
            port3_dir_q <= msr_pkg::MSR_RST_P3_DIR;
            port6_dir_q <= msr_pkg::MSR_RST_P6_DIR;
        end
        else
        begin
            internal_ram_enable_q <= regs_q[msr_pkg::MSR_RAM_P5_CTRL][msr_pkg::MSR_INTERNAL_RAM_ENABLE_BIT];
            port2_dir_q <= regs_q[msr_pkg::MSR_P2_DIR];
            port3_dir_q <= regs_q[msr_pkg::MSR_P3_DIR];
            port6_dir_q <= regs_q[msr_pkg::MSR_P6_DIR];
        end
    end

endmodule

`default_nettype wire

// ===== verif/msr_regmap_assertions.sv
// checker for the mode decode and the internal register area
// assumes binding to msr_regmap built with its internal rom present
`timescale 1ns/10ps
`default_nettype none

module msr_regmap_chk
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_select_pin_a,
    input wire logic mode_select_pin_b,
    input wire logic standby_input,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [15:0] capture_value,
    input wire logic [7:0] cpu_rdata_q,
    input wire logic cpu_rvalid_q,
    input wire logic reg_hit_q,
    input wire logic ext_access_q,
    input wire logic rom_access_q,
    input wire logic ram_access_q,
    input wire msr_pkg::msr_mode_t mode_q,
    input wire logic rom_enable_q,
    input wire logic ext_vectors_q,
    input wire logic ext_bus_enable_q,
    input wire logic cpu_hold_q,
    input wire logic internal_ram_enable_q,
    input wire logic [7:0] port2_dir_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ***************************************
    // assertions
    // ***************************************
    AST_DEC_EXP2:
    assert property (({mode_select_pin_b, mode_select_pin_a} == 2'b10)[*5] |->
        mode_q == msr_pkg::MSR_MODE_EXP2 && rom_enable_q && !ext_vectors_q && ext_bus_enable_q)
        else $error("mode 2 decode wrong");
    AST_DEC_PROM:
    assert property (({mode_select_pin_b, mode_select_pin_a, standby_input} == 3'b000)[*5]
        |-> mode_q == msr_pkg::MSR_MODE_PROM && cpu_hold_q)
        else $error("prom decode wrong");
    AST_EXP1:
    assert property (mode_q == msr_pkg::MSR_MODE_EXP1 && $past(mode_q) == msr_pkg::MSR_MODE_EXP1
        |-> ext_vectors_q && !rom_enable_q && ext_bus_enable_q && !rom_access_q)
        else $error("mode 1 outputs wrong");
    AST_SINGLE:
    assert property (mode_q == msr_pkg::MSR_MODE_SINGLE && $past(mode_q) == mode_q
        |-> rom_enable_q && !ext_bus_enable_q && !ext_access_q)
        else $error("single chip outputs wrong");
    AST_REG_READ:
    assert property (cpu_rd && !cpu_hold_q && cpu_addr <= 16'h001F |=> cpu_rvalid_q && reg_hit_q)
        else $error("register read not answered");
    AST_OUTSIDE:
    assert property (cpu_rd && cpu_addr > 16'h001F |=> !cpu_rvalid_q && !reg_hit_q)
        else $error("access outside register area answered");
    AST_HOLD:
    assert property (cpu_hold_q && cpu_rd |=> !cpu_rvalid_q)
        else $error("read answered while held");
    AST_CAP_READ:
    assert property (cpu_rd && !cpu_hold_q && cpu_addr == 16'h000D
        |=> cpu_rdata_q == $past(capture_value[15:8]))
        else $error("capture high read wrong");
    AST_WO_READ:
    assert property (cpu_rd && !cpu_hold_q && cpu_addr == 16'h0001 |=> cpu_rdata_q == 8'hFF)
        else $error("write-only read wrong");
    AST_DIR_WR:
    assert property (cpu_wr && !cpu_hold_q && cpu_addr == 16'h0001
        |-> ##2 port2_dir_q == $past(cpu_wdata, 2))
        else $error("port 2 direction not updated");
    AST_RAM_GATE:
    assert property (ram_access_q |-> $past(internal_ram_enable_q))
        else $error("ram hit while disabled");

    COV_READ: cover property (cpu_rvalid_q);
    COV_PROM: cover property (mode_q == msr_pkg::MSR_MODE_PROM);
    COV_RAM: cover property (ram_access_q);
endmodule

`default_nettype wire

// ===== verif/msr_ext_model.sv
// model of the peripherals and external bus cycle count beyond the block
// assumes one clock; peripheral values are steady constants
`timescale 1ns/10ps
`default_nettype none

module msr_ext_model
#(
    parameter logic [15:0] CAP_VAL = 16'hA53C,
    parameter logic [7:0] RX_VAL = 8'h6E,
    parameter logic [7:0] P5_VAL = 8'hC9
)
(
    input wire logic clk,
    input wire logic ext_access_q,
    output logic [15:0] capture_value,
    output logic [7:0] rx_data,
    output logic [7:0] port5_pins,
    output int ext_count
);
    int ext_cnt = 0;

    // ***************************************
    // peripheral levels and bus cycle count
    // ***************************************
    assign capture_value = CAP_VAL;
    assign rx_data = RX_VAL;
    assign port5_pins = P5_VAL;
    assign ext_count = ext_cnt;
    // every external cycle lands here
    always @(posedge clk)
    begin
        if (ext_access_q === 1'b1)
            ext_cnt <= ext_cnt + 1;
    end
endmodule

`default_nettype wire

// ===== verif/tb_msr_regmap.sv
// testbench for the mode decode and register area
// assumes the default build: internal rom, ram control resets to 7c
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) \
    begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_msr_regmap;
    logic clk = 1'b0;
    logic rst, mode_select_pin_a, mode_select_pin_b, standby_input, cpu_rd, cpu_wr;
    logic [15:0] cpu_addr, capture_value;
    logic [7:0] cpu_wdata, rx_data, port5_pins, cpu_rdata_q, port2_dir_q, port3_dir_q, port6_dir_q;
    logic cpu_rvalid_q, reg_hit_q, ext_access_q, rom_access_q, ram_access_q, rom_enable_q;
    logic ext_vectors_q, ext_bus_enable_q, cpu_hold_q, internal_ram_enable_q;
    msr_pkg::msr_mode_t mode_q;
    int num_errors = 0;
    int total_checks = 0;
    int ext_count, i;
    logic [4:0] ra [22] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0F, 5'h10, 5'h11, 5'h14,
        5'h19, 5'h1A, 5'h1B, 5'h1D, 5'h01, 5'h04, 5'h13, 5'h16, 5'h1C, 5'h00, 5'h05, 5'h1E, 5'h1F};
    logic [7:0] rv [22] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h10, 8'h00, 8'h20, 8'h7C,
        8'hFF, 8'hFF, 8'h20, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [4:0] wa [8] = '{5'h0B, 5'h1A, 5'h0D, 5'h0E, 5'h12, 5'h15, 5'h1E, 5'h13};
    logic [7:0] wv [8] = '{8'h12, 8'hC3, 8'hA5, 8'h3C, 8'h6E, 8'hC9, 8'hFF, 8'hFF};
    logic [2:0] mp [4] = '{3'b011, 3'b101, 3'b111, 3'b000};
    logic [6:0] me [4] = '{7'h16, 7'h2A, 7'h38, 7'h41};

    msr_regmap i_dut (.clk, .rst, .mode_select_pin_a, .mode_select_pin_b, .standby_input,
        .port5_pins, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .capture_value, .rx_data,
        .cpu_rdata_q, .cpu_rvalid_q, .reg_hit_q, .ext_access_q, .rom_access_q, .ram_access_q,
        .mode_q, .rom_enable_q, .ext_vectors_q, .ext_bus_enable_q, .cpu_hold_q,
        .internal_ram_enable_q, .port2_dir_q, .port3_dir_q, .port6_dir_q);
    msr_ext_model i_ext (.clk, .ext_access_q, .capture_value, .rx_data, .port5_pins,
        .ext_count);

    always #12.5 clk = ~clk;

    // ***************************************
    // access tasks and closing
    // ***************************************
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic v);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        `CHK("rvalid", v, cpu_rvalid_q)
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #(3000 * 25);
        num_errors++;
        stop_test();
    end

    initial
    begin
        rst = 1'b1;
        {mode_select_pin_b, mode_select_pin_a, standby_input} = 3'b111;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("dirs", 24'hFC_FE00, {port2_dir_q, port3_dir_q, port6_dir_q})
        `CHK("ram_en", 1'b1, internal_ram_enable_q)
        for (i = 0; i < 22; i++)
        begin
            rd({11'h000, ra[i]}, 1'b1);
            `CHK("reset", rv[i], cpu_rdata_q)
        end
        // writes must land in read-write places and not in read-only and reserved ones
        wr(16'h000B, 8'h12);
        wr(16'h001A, 8'hC3);
        wr(16'h000D, 8'h77);
        wr(16'h0015, 8'h77);
        wr(16'h001E, 8'h55);
        wr(16'h0013, 8'h99);
        for (i = 0; i < 8; i++)
        begin
            rd({11'h000, wa[i]}, 1'b1);
            `CHK("rdback", wv[i], cpu_rdata_q)
        end
        wr(16'h0001, 8'h5A);
        wr(16'h0004, 8'hA5);
        wr(16'h0016, 8'h3C);
        @(negedge clk);
        `CHK("dirs", 24'h5A_A53C, {port2_dir_q, port3_dir_q, port6_dir_q})
        rd(16'h0040, 1'b0);
        `CHK("ram_hit", 2'b10, {ram_access_q, ext_access_q})
        wr(16'h0014, 8'h3C);
        @(negedge clk);
        `CHK("ram_en", 1'b0, internal_ram_enable_q)
        rd(16'h0040, 1'b0);
        `CHK("ram_off", 1'b0, ram_access_q)
        wr(16'h0014, 8'h7C);
        for (i = 0; i < 4; i++)
        begin
            @(negedge clk);
            {mode_select_pin_b, mode_select_pin_a, standby_input} = mp[i];
            repeat (5) @(negedge clk);
            `CHK("mode", me[i], {mode_q, rom_enable_q, ext_vectors_q, ext_bus_enable_q,
                cpu_hold_q})
            rd(16'hF000, 1'b0);
            `CHK("rom", me[i][3], rom_access_q)
            rd(16'h8000, 1'b0);
            `CHK("ext", me[i][1], ext_access_q)
            rd(16'h0000, !me[i][0]);
            `CHK("hit", !me[i][0], reg_hit_q)
        end
        `CHK("ext_cycles", 3, ext_count)
        stop_test();
    end
endmodule

bind msr_regmap msr_regmap_chk i_chk (.clk, .rst, .mode_select_pin_a, .mode_select_pin_b,
    .standby_input, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .capture_value, .cpu_rdata_q,
    .cpu_rvalid_q, .reg_hit_q, .ext_access_q, .rom_access_q, .ram_access_q, .mode_q,
    .rom_enable_q, .ext_vectors_q, .ext_bus_enable_q, .cpu_hold_q, .internal_ram_enable_q,
    .port2_dir_q);

`default_nettype wire
